// [inc/afec_pkg.sv]
// Purpose: Shared constants for the auxiliary latch and event counter block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package afec_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_COUNT_VALUE = 12'h000;     // Event count, read only
   localparam logic [11:0] OFF_COUNT_THRESH = 12'h004;    // Reach threshold
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;      // Sticky events, read only
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h00c;      // Interrupt enable
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h010;       // Write one to clear
   localparam logic [11:0] OFF_STATE = 12'h014;           // Live output state
   // Reset values
   localparam logic [31:0] THRESH_RESET = 32'h0000_0000;  // Threshold after reset
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;   // Count after reset
   // Interrupt bit positions
   localparam int IRQ_LATCH_SET = 0;     // Latch went high
   localparam int IRQ_LATCH_CLR = 1;     // Latch went low
   localparam int IRQ_COUNT = 2;         // Count pulse seen
   localparam int IRQ_REACHED = 3;       // Reach flag rose
   localparam int IRQ_BITS = 4;          // Number of event bits
   // Scan timing: inputs are sampled once per scan period
   localparam int CLK_FREQ_HZ = 125_000_000;  // pclk rate
   localparam int SCAN_PERIOD_US = 1000;      // Scan every 1 ms, half the min pulse
   localparam int SCAN_CYCLES = CLK_FREQ_HZ / 1_000_000 * SCAN_PERIOD_US;  // 125000
   localparam int MIN_PULSE_MS = 2;           // Least pulse width the source keeps
endpackage

// [core/afec_scan_tick.sv]
// Purpose: Periodic scan strobe generator
// Assumes: Single clock, asynchronous active-low reset
// Notes: One-cycle pulse every PERIOD cycles
`timescale 1ns/1ns
module afec_scan_tick #(
   parameter int PERIOD = afec_pkg::SCAN_CYCLES  // Cycles between strobes
) (
   input wire logic pclk,      // Clock
   input wire logic presetn,   // Async reset, active low
   output logic tick           // Scan strobe, one cycle
);
   logic [31:0] cnt_q;  // Cycle counter
   wire wrap = (cnt_q == 32'(PERIOD - 1));  // End of period

   // Free-running divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         cnt_q <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
         tick <= wrap;
      end
   end
endmodule

// [core/afec_edge_scan.sv]
// Purpose: Scanned sampler with rising-edge detection for function inputs
// Assumes: Inputs synchronous to pclk
// Notes: Edge seen only between two successive scan samples
`timescale 1ns/1ns
module afec_edge_scan #(
   parameter int N = 4  // Number of inputs
) (
   input wire logic pclk,        // Clock
   input wire logic presetn,     // Async reset, active low
   input wire logic tick,        // Scan strobe
   input wire logic [N-1:0] din, // Raw inputs
   output logic [N-1:0] rise     // One-cycle rising edge pulses
);
   logic [N-1:0] samp_q;  // Last scan sample

   // Sample on scan, compare to previous sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_q <= '0;
         rise <= '0;
      end else if (tick) begin
         samp_q <= din;
         rise <= din & ~samp_q;
      end else begin
         rise <= '0;
      end
   end
endmodule

// [core/afec_top.sv]
// Purpose: Auxiliary set/reset latch and scanned event counter with APB registers
// Assumes: APB3 slave, zero wait states, pclk at 125 MHz
// Notes: Inputs are scanned, so short pulses can be missed
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module afec_top #(
   parameter int SCAN_CYCLES = afec_pkg::SCAN_CYCLES  // Cycles per scan period
) (
   input wire logic pclk,            // Clock
   input wire logic presetn,         // Async reset, active low
   input wire logic psel,            // APB select
   input wire logic penable,         // APB access phase
   input wire logic pwrite,          // APB direction
   input wire logic [11:0] paddr,    // APB byte address
   input wire logic [31:0] pwdata,   // APB write data
   output logic [31:0] prdata,       // APB read data
   output logic pready,              // APB ready
   output logic pslverr,             // APB error
   input wire logic latch_reset_in,  // Latch reset function input
   input wire logic latch_set_in,    // Latch set function input
   input wire logic count_pulse_in,  // Count pulse function input
   input wire logic count_clear_in,  // Count clear function input
   output logic latch_state_out,     // Latch state
   output logic count_reached_out,   // Count reached
   output logic irq                  // Level interrupt
);
   logic tick;                 // Scan strobe
   logic [3:0] rise;           // Scanned rising edges
   logic [31:0] count_q;       // Event count
   logic [31:0] thresh_q;      // Reach threshold
   logic [3:0] sts_q;          // Sticky interrupt status
   logic [3:0] ien_q;          // Interrupt enable

   // Edge roles
   wire rst_edge = rise[0];
   wire set_edge = rise[1];
   wire cnt_edge = rise[2];
   wire clr_edge = rise[3];

   // Scan timebase
   afec_scan_tick #(.PERIOD(SCAN_CYCLES)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   // Periodic sampler; no direct edge logic on the pins
   afec_edge_scan #(.N(4)) u_scan (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .din({count_clear_in, count_pulse_in, latch_set_in, latch_reset_in}),
      .rise(rise)
   );

   // APB decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_val = (paddr == afec_pkg::OFF_COUNT_VALUE);
   wire hit_thr = (paddr == afec_pkg::OFF_COUNT_THRESH);
   wire hit_sts = (paddr == afec_pkg::OFF_IRQ_STATUS);
   wire hit_ien = (paddr == afec_pkg::OFF_IRQ_ENABLE);
   wire hit_clr = (paddr == afec_pkg::OFF_IRQ_CLEAR);
   wire hit_st = (paddr == afec_pkg::OFF_STATE);
   wire hit_any = hit_val | hit_thr | hit_sts | hit_ien | hit_clr | hit_st;
   // Writes to read-only words are refused with an error
   wire bad = ~hit_any | (pwrite & (hit_val | hit_sts | hit_st)) | (~pwrite & hit_clr);

   // Next count: clear wins over a pulse in the same scan
   wire [31:0] count_d = clr_edge ? afec_pkg::COUNT_RESET :
                         cnt_edge ? count_q + 32'h0000_0001 :
                         count_q;
   wire [31:0] thresh_d = (wr & hit_thr) ? pwdata : thresh_q;
   // Compare uses the values in force next cycle
   wire reached_d = (count_d >= thresh_d);

   // Next latch state: reset edge dominates a simultaneous set
   wire latch_d = rst_edge ? 1'b0 : set_edge ? 1'b1 : latch_state_out;

   // Events; set wins over a software clear
   wire [3:0] ev;
   assign ev[afec_pkg::IRQ_LATCH_SET] = latch_d & ~latch_state_out;
   assign ev[afec_pkg::IRQ_LATCH_CLR] = ~latch_d & latch_state_out;
   assign ev[afec_pkg::IRQ_COUNT] = cnt_edge;
   assign ev[afec_pkg::IRQ_REACHED] = reached_d & ~count_reached_out;
   wire [3:0] clr_mask = (wr & hit_clr) ? pwdata[3:0] : 4'h0;
   wire [3:0] sts_d = (sts_q & ~clr_mask) | ev;

   // Read mux
   wire [31:0] rdata_d = hit_val ? count_q :
                         hit_thr ? thresh_q :
                         hit_sts ? {28'h0000000, sts_q} :
                         hit_ien ? {28'h0000000, ien_q} :
                         hit_st ? {30'h00000000, count_reached_out, latch_state_out} :
                         32'h0000_0000;

   // Counter and threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= afec_pkg::COUNT_RESET;
         thresh_q <= afec_pkg::THRESH_RESET;
      end else begin
         count_q <= count_d;
         thresh_q <= thresh_d;
      end
   end

   // Output flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_state_out <= 1'b0;
         // Reset state of the compare, so no false change once reset lifts
         count_reached_out <= (afec_pkg::COUNT_RESET >= afec_pkg::THRESH_RESET);
      end else begin
         latch_state_out <= latch_d;
         count_reached_out <= reached_d;
      end
   end

   // Interrupt state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= 4'h0;
         ien_q <= 4'h0;
         irq <= 1'b0;
      end else begin
         sts_q <= sts_d;
         if (wr & hit_ien) begin
            ien_q <= pwdata[3:0];
         end
         irq <= |(sts_d & ((wr & hit_ien) ? pwdata[3:0] : ien_q));
      end
   end

   // APB answer: ready in the access cycle after setup, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & bad;
         prdata <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
      end
   end

   // Checks
   a_latch_reset: assert property (@(posedge pclk) disable iff (!presetn)
      rst_edge |=> !latch_state_out) else $error("latch not low after reset edge");
   a_latch_set: assert property (@(posedge pclk) disable iff (!presetn)
      set_edge && !rst_edge |=> latch_state_out) else $error("latch not high");
   a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !set_edge && !rst_edge |=> $stable(latch_state_out)) else $error("latch moved");
   a_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_edge && !clr_edge |=> count_q == $past(count_q) + 32'h1) else $error("no inc");
   a_count_still: assert property (@(posedge pclk) disable iff (!presetn)
      !cnt_edge && !clr_edge |=> $stable(count_q)) else $error("count moved");
   a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
      clr_edge |=> count_q == 32'h0) else $error("count not cleared");
   a_reach_flag: assert property (@(posedge pclk) disable iff (!presetn)
      count_reached_out == (count_q >= thresh_q)) else $error("reach wrong");
   a_reach_drop: assert property (@(posedge pclk) disable iff (!presetn)
      clr_edge && thresh_q != 32'h0 && !(wr & hit_thr) |=> !count_reached_out)
      else $error("reach stuck after clear");
   a_scan_only: assert property (@(posedge pclk) disable iff (!presetn)
      !tick |=> rise == 4'h0) else $error("edge outside scan");

   // Edges only appear one cycle after a scan strobe
   a_rise_after_tick: assert property (@(posedge pclk) disable iff (!presetn)
      |rise |-> $past(tick))
      else $error("edge without scan strobe");

   // Strobe is a single-cycle pulse
   a_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> !tick)
      else $error("scan strobe too long");

   // Bus phases as seen by the slave
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   // A full transfer: setup then access
   sequence s_xfer;
      s_setup ##1 s_access;
   endsequence

   // Ready answers the setup cycle
   a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup |=> pready)
      else $error("no ready after setup");

   // Ready lasts one cycle per transfer
   a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
      s_xfer |=> !pready)
      else $error("ready held too long");

   // No ready while the bus is idle
   a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !psel |=> !pready)
      else $error("ready while idle");

   // Refused words answer with an error
   a_err_refused: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && bad |=> pslverr)
      else $error("refused access without error");

   // Good words answer cleanly
   a_err_clean: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !bad |=> !pslverr)
      else $error("error on good access");

   // Error only alongside ready
   a_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable) |=> !pslverr)
      else $error("error outside a transfer");

   // Read data is zero outside read answers
   a_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> prdata == 32'h0000_0000)
      else $error("stray read data");

   // Count reads return the count at setup
   a_rdata_count: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_val |=> prdata == $past(count_q))
      else $error("count read wrong");

   // Threshold reads return the stored threshold
   a_rdata_thr: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_thr |=> prdata == $past(thresh_q))
      else $error("threshold read wrong");

   // State reads mirror the two output flags
   a_rdata_state: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_st
      |=> prdata[1:0] == $past({count_reached_out, latch_state_out}))
      else $error("state read wrong");

   // Threshold takes the written word
   a_thr_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_thr |=> thresh_q == $past(pwdata))
      else $error("threshold not written");

   // Threshold holds without a write
   a_thr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && hit_thr) |=> $stable(thresh_q))
      else $error("threshold moved");

   // Enable takes the written bits
   a_ien_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_ien |=> ien_q == $past(pwdata[3:0]))
      else $error("enable not written");

   // Enable holds without a write
   a_ien_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && hit_ien) |=> $stable(ien_q))
      else $error("enable moved");

   // Threshold zero means always reached
   a_reach_zero: assert property (@(posedge pclk) disable iff (!presetn)
      thresh_q == 32'h0000_0000 |-> count_reached_out)
      else $error("reach low at zero threshold");

   // Interrupt level follows enabled status
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(sts_q & ien_q))
      else $error("interrupt level wrong");

   // Status bits only fall by a software clear
   a_sts_keep: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ($past(sts_q) & ~$past(clr_mask) & ~sts_q) == 4'h0)
      else $error("status lost without clear");

   // Event wins over a clear in the same cycle
   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_edge && wr && hit_clr && pwdata[afec_pkg::IRQ_COUNT]
      |=> sts_q[afec_pkg::IRQ_COUNT])
      else $error("clear beat count event");

   // Latch rise is recorded
   a_ev_rise: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(latch_state_out) |-> sts_q[afec_pkg::IRQ_LATCH_SET])
      else $error("latch rise not recorded");

   // Latch fall is recorded
   a_ev_fall: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(latch_state_out) |-> sts_q[afec_pkg::IRQ_LATCH_CLR])
      else $error("latch fall not recorded");

   // Reach rise is recorded
   a_ev_reach: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(count_reached_out) |-> sts_q[afec_pkg::IRQ_REACHED])
      else $error("reach rise not recorded");
endmodule

// [verification/afec_fn_model.sv]
// Purpose: Model of the drive's function mapping that feeds the four inputs
// Assumes: HOLD spans more than two scan periods of the design
// Notes: Each request on an idle line gives one high pulse, then an equal low gap
`timescale 1ns/1ns
module afec_fn_model #(
   parameter int HOLD = 24  // High time and low gap, in cycles
) (
   input wire logic pclk,      // Clock
   input wire logic presetn,   // Async reset, active low
   input wire logic [3:0] go,  // One-cycle pulse requests
   output logic [3:0] fn,      // Function lines, idle low
   output logic busy           // Some pulse or gap still running
);
   int cnt_q [4];  // Cycles left per line
   // Request ignored while a line is busy, so no pulse is cut short
   always_ff @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 4; i++) begin
         if (!presetn) cnt_q[i] <= 0;
         else if (go[i] && cnt_q[i] == 0) cnt_q[i] <= 2 * HOLD;
         else if (cnt_q[i] != 0) cnt_q[i] <= cnt_q[i] - 1;
      end
   end
   // High for HOLD cycles, low as long after: wider than the scan needs
   always_comb begin
      busy = 1'b0;
      for (int i = 0; i < 4; i++) begin
         fn[i] = cnt_q[i] > HOLD;
         busy = busy | (cnt_q[i] != 0);
      end
   end
endmodule

// [verification/tb_aux_flipflop_and_event_counter.sv]
// Purpose: Self-checking bench for the latch and scanned event counter
// Assumes: Short scan period of 8 cycles in place of 1 ms
// Notes: Random thresholds and pulse counts, seed fixed
`timescale 1ns/1ns
module tb_aux_flipflop_and_event_counter;
   localparam int SCAN = 8;  // Shortened scan period
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;  // APB address
   logic [31:0] pwdata = 32'h0, prdata, rd;  // APB data
   logic pready, pslverr, err, latch_state_out, count_reached_out, irq, busy;
   logic [3:0] go = 4'h0, fn;  // Pulse requests and function lines
   int fail_count = 0, num_checks = 0, thr, n;
   afec_top #(.SCAN_CYCLES(SCAN)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .latch_reset_in(fn[0]),
      .latch_set_in(fn[1]), .count_pulse_in(fn[2]), .count_clear_in(fn[3]),
      .latch_state_out(latch_state_out), .count_reached_out(count_reached_out), .irq(irq));
   afec_fn_model #(.HOLD(3 * SCAN)) fnm (.pclk(pclk), .presetn(presetn), .go(go),
      .fn(fn), .busy(busy));
   // Clock at 125 MHz
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Reached is a compare, not an equality
   function automatic logic reach_exp(input int c, input int t);
      return c >= t;
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask
   // One APB transfer; idle cycle first so strobes never double up
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         fail_count++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the access edge settle before anyone looks at outputs
      @(negedge pclk);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   // Ask the model for pulses and wait until its gap has passed
   task automatic pulse(input logic [3:0] m);
      int k;
      @(posedge pclk);
      go <= m;
      @(posedge pclk);
      go <= 4'h0;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (busy !== 1'b0 && k < 300);
      if (k >= 300) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   initial begin
      void'($urandom(20));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("thresh", afec_pkg::OFF_COUNT_THRESH, afec_pkg::THRESH_RESET);
      rd_chk("count", afec_pkg::OFF_COUNT_VALUE, afec_pkg::COUNT_RESET);
      // Latch: repeated set, repeated reset, both in one scan
      apb(1'b1, afec_pkg::OFF_IRQ_ENABLE, 32'h1);
      pulse(4'h2);
      check("latch", latch_state_out, 1'b1);
      check("irq", irq, 1'b1);
      pulse(4'h2);
      check("latch", latch_state_out, 1'b1);
      apb(1'b1, afec_pkg::OFF_IRQ_CLEAR, 32'hf);
      check("irq", irq, 1'b0);
      for (int i = 0; i < 2; i++) begin
         pulse(4'h1);
         check("latch", latch_state_out, 1'b0);
      end
      pulse(4'h2);
      pulse(4'h3);
      check("latch", latch_state_out, 1'b0);
      $display("latch test done");
      // Counter rounds with documented and random thresholds
      apb(1'b1, afec_pkg::OFF_IRQ_ENABLE, 32'h4);
      for (int r = 0; r < 3; r++) begin
         thr = (r == 0) ? 2 : $urandom_range(1, 6);
         n = $urandom_range(1, 7);
         apb(1'b1, afec_pkg::OFF_COUNT_THRESH, thr);
         pulse(4'h8);
         rd_chk("count", afec_pkg::OFF_COUNT_VALUE, 32'h0);
         check("reached", count_reached_out, 1'b0);
         for (int i = 1; i <= n; i++) begin
            pulse(4'h4);
            check("reached", count_reached_out, reach_exp(i, thr));
         end
         rd_chk("count", afec_pkg::OFF_COUNT_VALUE, n);
         rd_chk("state", afec_pkg::OFF_STATE, {30'h0, reach_exp(n, thr), 1'b0});
         check("irq", irq, 1'b1);
         apb(1'b1, afec_pkg::OFF_IRQ_CLEAR, 32'hf);
         check("irq", irq, 1'b0);
      end
      pulse(4'hc);
      rd_chk("count", afec_pkg::OFF_COUNT_VALUE, 32'h0);
      check("reached", count_reached_out, 1'b0);
      apb(1'b1, afec_pkg::OFF_IRQ_ENABLE, 32'h0);
      pulse(4'h4);
      check("irq", irq, 1'b0);
      $display("counter test done");
      // Refused write to the read-only count, unmapped read
      apb(1'b1, afec_pkg::OFF_COUNT_VALUE, 32'h5);
      check("pslverr", err, 1'b1);
      rd_chk("count", afec_pkg::OFF_COUNT_VALUE, 32'h1);
      apb(1'b0, 12'h020, 32'h0);
      check("pslverr", err, 1'b1);
      $display("register test done");
      report_and_stop();
   end
endmodule
